// >>> core/cib_pkg.sv
// constants and types for the central io bus port, processor end
// assumes a single 125 MHz clock domain and synchronous reset
package cib_pkg;
  localparam int unsigned CIB_DATA_W     = 32;
  localparam int unsigned CIB_PAR_W      = 4;
  localparam int unsigned CIB_SEL_W      = 6;
  localparam int unsigned CIB_CMD_W      = 10;
  localparam int unsigned CIB_SEL_ONES   = 3;
  localparam int unsigned CIB_INH_BIT_A  = 9;
  localparam int unsigned CIB_INH_BIT_B  = 30;
  localparam int unsigned CIB_CLK_MHZ    = 125;
  localparam int unsigned CIB_TMO_NS     = 8000;
  localparam int unsigned CIB_TMO_CYC    = (CIB_TMO_NS * CIB_CLK_MHZ) / 1000;
  localparam logic [31:0] CIB_HOLD_RST   = 32'h0000_0000;
  // command order matches pulse line positions
  localparam int unsigned CMD_RD_DATA    = 0;
  localparam int unsigned CMD_RD_STAT    = 1;
  localparam int unsigned CMD_RD_INT     = 2;
  localparam int unsigned CMD_RD_SREQ    = 3;
  localparam int unsigned CMD_INT_ACK    = 4;
  localparam int unsigned CMD_ERR_ACK    = 5;
  localparam int unsigned CMD_IDLE       = 6;
  localparam int unsigned CMD_CLR_ERR    = 7;
  localparam int unsigned CMD_WR_DATA    = 8;
  localparam int unsigned CMD_WR_CTL     = 9;
  typedef enum logic [1:0] {CIB_IDLE, CIB_PULSE, CIB_WAIT} cib_state_t;
endpackage : cib_pkg

// >>> core/cib_port.sv
// processor end of the central io bus: issues one command, waits for reply
// assumes remote replies and interrupts arrive asynchronous to i_clk
`timescale 1ns/1ps
module cib_port
  import cib_pkg::*;
#(
  parameter int unsigned TMO_CYC = CIB_TMO_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire logic                  i_cmd_go,
  input  wire logic [CIB_CMD_W-1:0]  i_cmd_sel,
  input  wire logic [CIB_SEL_W-1:0]  i_chan_sel,
  input  wire logic [CIB_DATA_W-1:0] i_wr_data,
  input  wire logic [31:0]           i_sys_state,
  input  wire logic [35:0]           i_io_data_lines,
  input  wire logic [CIB_SEL_W-1:0]  i_response_code_lines,
  input  wire logic                  i_reply_ready_line,
  input  wire logic                  i_all_well_line,
  input  wire logic                  i_summary_fault_line,
  input  wire logic [5:0]            i_irq_lines,
  output logic [35:0]                o_io_data_lines,
  output logic                       o_io_data_oe,
  output logic [CIB_SEL_W-1:0]       o_channel_select_lines,
  output logic [CIB_CMD_W-1:0]       o_pulse_point_reg,
  output logic                       o_io_block_line,
  output logic [CIB_DATA_W-1:0]      o_channel_data_holding_reg,
  output logic                       o_busy,
  output logic                       o_done,
  output logic                       o_ack_err,
  output logic                       o_ready_err,
  output logic                       o_par_err,
  output logic                       o_cmd_err,
  output logic                       o_fault,
  output logic                       o_all_well,
  output logic [5:0]                 o_irq
);
  // the down-counter needs room for the two sync stages plus a reply
  if (TMO_CYC < 2 || TMO_CYC > 1000000) begin : g_bad_tmo
    $error("cib_port: bad TMO_CYC");
  end

  function automatic logic [3:0] byte_par(input logic [31:0] d);
    for (int i = 0; i < 4; i++) byte_par[i] = ^d[8*i +: 8];
  endfunction : byte_par

  // two-stage synchronisers for all remote lines
  logic [35:0] dat_s1_q, dat_s2_q;
  logic [5:0]  ack_s1_q, ack_s2_q, irq_s1_q, irq_s2_q;
  logic [2:0]  rsp_s1_q, rsp_s2_q;
  always_ff @(posedge i_clk) begin
    dat_s1_q <= i_io_data_lines;
    dat_s2_q <= dat_s1_q;
    ack_s1_q <= i_response_code_lines;
    ack_s2_q <= ack_s1_q;
    irq_s1_q <= i_irq_lines;
    irq_s2_q <= irq_s1_q;
    rsp_s1_q <= {i_reply_ready_line, i_all_well_line, i_summary_fault_line};
    rsp_s2_q <= rsp_s1_q;
  end
  wire rdy_s   = rsp_s2_q[2];
  wire well_s  = rsp_s2_q[1];
  wire fault_s = rsp_s2_q[0];

  cib_state_t st_q, st_d;
  logic [CIB_CMD_W-1:0]  cmd_q;
  logic [CIB_SEL_W-1:0]  sel_q;
  logic [CIB_DATA_W-1:0] hold_q;
  logic [31:0]           tmo_q;
  logic                  done_q, ack_err_q, rdy_err_q, par_err_q, cmd_err_q, blk_q;
  logic                  rdy_low_q, busy_q;

  wire cmd_onehot = $onehot(i_cmd_sel);
  wire sel_valid  = ($countones(i_chan_sel) == CIB_SEL_ONES);
  wire is_read    = |cmd_q[CMD_RD_SREQ:CMD_RD_DATA];
  wire is_write   = cmd_q[CMD_WR_DATA] | cmd_q[CMD_WR_CTL];
  wire start      = (st_q == CIB_IDLE) && i_cmd_go;
  wire start_ok   = start && cmd_onehot && sel_valid;
  wire ack_ok     = (ack_s2_q == sel_q);
  // ready and ack of the last command linger two sync stages after it ends;
  // so a reply is only taken once ready has been seen low since the go (rdy_low_q)
  wire reply      = (st_q == CIB_WAIT) && rdy_s && rdy_low_q && ack_ok;
  wire timeout    = (st_q == CIB_WAIT) && (tmo_q == 32'h0000_0000);
  wire rd_par_bad = (byte_par(dat_s2_q[31:0]) != dat_s2_q[35:32]);

  always_comb begin
    st_d = st_q;
    case (st_q)
      CIB_IDLE:  if (start_ok) st_d = CIB_PULSE;
      CIB_PULSE: st_d = CIB_WAIT;
      CIB_WAIT:  if (reply || timeout) st_d = CIB_IDLE;
      default:   st_d = CIB_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q      <= CIB_IDLE;
      cmd_q     <= '0;
      sel_q     <= '0;
      hold_q    <= CIB_HOLD_RST;
      tmo_q     <= 32'h0000_0000;
      done_q    <= 1'b0;
      ack_err_q <= 1'b0;
      rdy_err_q <= 1'b0;
      par_err_q <= 1'b0;
      cmd_err_q <= 1'b0;
      blk_q     <= 1'b0;
      rdy_low_q <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      done_q    <= reply || timeout;
      blk_q     <= i_sys_state[CIB_INH_BIT_A] | i_sys_state[CIB_INH_BIT_B];
      cmd_err_q <= start && !(cmd_onehot && sel_valid);
      busy_q    <= (st_d != CIB_IDLE);
      if (start_ok) rdy_low_q <= 1'b0;
      else if (st_q == CIB_WAIT && !rdy_s) rdy_low_q <= 1'b1;
      if (start_ok) begin
        cmd_q     <= i_cmd_sel;
        sel_q     <= i_chan_sel;
        hold_q    <= i_wr_data;
        tmo_q     <= TMO_CYC;
        ack_err_q <= 1'b0;
        rdy_err_q <= 1'b0;
        par_err_q <= 1'b0;
      end else if (st_q == CIB_WAIT && tmo_q != 32'h0000_0000) begin
        tmo_q <= tmo_q - 32'h0000_0001;
      end
      if (reply && is_read) begin
        hold_q    <= dat_s2_q[31:0];
        par_err_q <= rd_par_bad;
      end
      if (timeout) begin
        ack_err_q <= !ack_ok;
        rdy_err_q <= !rdy_s;
      end
      if (st_q == CIB_WAIT && reply == 1'b0 && timeout == 1'b0 && st_d != CIB_WAIT)
        cmd_q <= '0;
    end
  end

  // pulse lines only during the one-cycle command phase
  logic [CIB_CMD_W-1:0] ppr_q;
  logic                 oe_q;
  logic [35:0]          dout_q;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ppr_q  <= '0;
      oe_q   <= 1'b0;
      dout_q <= '0;
    end else begin
      ppr_q  <= (st_d == CIB_PULSE) ? i_cmd_sel : '0;
      // drive data on every command but the four reads; remote drives on reads
      oe_q   <= (st_d == CIB_PULSE || st_d == CIB_WAIT) && !is_read_d(st_d);
      dout_q <= {byte_par(hold_d()), hold_d()};
    end
  end

  function automatic logic is_read_d(input cib_state_t s);
    is_read_d = (s == CIB_PULSE) ? |i_cmd_sel[CMD_RD_SREQ:CMD_RD_DATA] : is_read;
  endfunction : is_read_d

  function automatic logic [31:0] hold_d();
    hold_d = start_ok ? i_wr_data : hold_q;
  endfunction : hold_d

  assign o_io_data_lines            = dout_q;
  assign o_io_data_oe               = oe_q;
  assign o_channel_select_lines     = sel_q;
  assign o_pulse_point_reg          = ppr_q;
  assign o_io_block_line            = blk_q;
  assign o_channel_data_holding_reg = hold_q;
  assign o_busy                     = busy_q;
  assign o_done                     = done_q;
  assign o_ack_err                  = ack_err_q;
  assign o_ready_err                = rdy_err_q;
  assign o_par_err                  = par_err_q;
  assign o_cmd_err                  = cmd_err_q;
  assign o_fault                    = fault_s;
  assign o_all_well                 = well_s;
  assign o_irq                      = irq_s2_q;

  chk_one_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
    $onehot0(o_pulse_point_reg)) else $error("more than one command pulse");
  chk_sel_weight: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_pulse_point_reg != '0) |-> ($countones(o_channel_select_lines) == CIB_SEL_ONES))
    else $error("select code weight wrong");
  chk_block_or: assert property (@(posedge i_clk) disable iff (i_srst)
    ##1 o_io_block_line == ($past(i_sys_state[CIB_INH_BIT_A]) |
    $past(i_sys_state[CIB_INH_BIT_B])))
    else $error("io block not OR of state bits");
  chk_par_even: assert property (@(posedge i_clk) disable iff (i_srst)
    o_io_data_oe |-> (byte_par(o_io_data_lines[31:0]) == o_io_data_lines[35:32]))
    else $error("write parity wrong");
  sequence s_issue; o_pulse_point_reg != '0; endsequence
  chk_single_cmd: assert property (@(posedge i_clk) disable iff (i_srst)
    s_issue |=> (o_pulse_point_reg == '0) [*2]) else $error("command overlap");
  chk_wr_data: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_pulse_point_reg[CMD_WR_DATA]) |-> o_io_data_oe &&
    o_io_data_lines[31:0] == o_channel_data_holding_reg) else $error("write data mismatch");
  chk_rd_float: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_pulse_point_reg[CMD_RD_DATA]) |-> !o_io_data_oe) else $error("driving on read");
  chk_timeout: assert property (@(posedge i_clk) disable iff (i_srst)
    (timeout && !ack_ok) |=> o_ack_err && o_done) else $error("missing ack error");
  chk_done_idle: assert property (@(posedge i_clk) disable iff (i_srst)
    o_done |-> !o_busy && $past(o_busy)) else $error("done without a finished command");
endmodule : cib_port

// >>> sim/cib_far_end.sv
// far end model: a transfer controller answering every command pulse outside mode 2
// assumes cib_port pulses; replies are held until busy falls
`timescale 1ns/1ps
module cib_far_end (
  input  wire logic        i_clk,
  input  wire logic [9:0]  i_ppr,
  input  wire logic [5:0]  i_sel,
  input  wire logic        i_busy,
  input  wire logic [1:0]  i_mode,
  input  wire logic [3:0]  i_dly,
  input  wire logic [31:0] i_rdata,
  input  wire logic [35:0] i_bus,
  output logic      [35:0] o_data,
  output logic      [5:0]  o_ack,
  output logic             o_rdy,
  output logic             o_perr
);
  function automatic logic [3:0] even_par(input logic [31:0] d);
    for (int i = 0; i < 4; i++) even_par[i] = ^d[8*i +: 8];
  endfunction : even_par

  initial begin
    logic rd;
    int   n;
    {o_data, o_ack, o_rdy, o_perr} = '0;
    forever begin
      @(negedge i_clk);
      // mode 2 stays silent so the timeout path is reached
      if (|i_ppr && i_mode != 2'h2) begin
        rd = |i_ppr[3:0];
        // data-carrying commands: check the parity the port drives
        o_perr = !rd && (even_par(i_bus[31:0]) != i_bus[35:32]);
        @(posedge i_clk);
        repeat (i_dly) @(posedge i_clk);
        #1;
        // mode 3 spoils byte 0 parity to exercise the port's read check
        if (rd) o_data = {even_par(i_rdata) ^ {3'h0, i_mode == 2'h3}, i_rdata};
        o_ack = (i_mode == 2'h1) ? ~i_sel : i_sel;
        o_rdy = 1'b1;
        for (n = 0; n < 200 && i_busy; n++) @(negedge i_clk);
        @(posedge i_clk);
        #1;
        {o_ack, o_rdy} = '0;
        // released bus shows inverse so stale data cannot pass
        o_data = ~o_data;
      end
    end
  end
endmodule : cib_far_end

// >>> sim/cib_port_tb.sv
// bench for the processor end of the central io bus
// assumes cib_far_end as the remote controller, timeout shortened to 20
`timescale 1ns/1ps
module cib_port_tb;
  import cib_pkg::*;
  logic        i_clk, i_srst, i_cmd_go, i_all_well_line, i_summary_fault_line;
  logic [9:0]  i_cmd_sel, pulse_point_reg;
  logic [5:0]  i_chan_sel, ack, sel, i_irq_lines, o_irq;
  logic [31:0] i_wr_data, i_sys_state, rdata, hold;
  logic [35:0] dq, o_dq, far_dq;
  logic        oe, rdy, busy, done, aerr, rerr, blk, cerr, fault, well, perr, far_perr;
  logic [1:0]  mode;
  logic [3:0]  dly;
  int          err_total, samples_checked, n_cerr, k;
  logic [43:0] qd[$];
  logic [51:0] qp[$];
  assign dq = oe ? o_dq : far_dq;
  cib_port #(.TMO_CYC(20)) cib_port_i (.i_clk, .i_srst, .i_cmd_go, .i_cmd_sel, .i_chan_sel,
    .i_wr_data, .i_sys_state, .i_io_data_lines(dq), .i_response_code_lines(ack),
    .i_reply_ready_line(rdy), .i_all_well_line, .i_summary_fault_line, .i_irq_lines,
    .o_io_data_lines(o_dq), .o_io_data_oe(oe), .o_channel_select_lines(sel),
    .o_pulse_point_reg(pulse_point_reg), .o_io_block_line(blk), .o_channel_data_holding_reg(hold),
    .o_busy(busy), .o_done(done), .o_ack_err(aerr), .o_ready_err(rerr), .o_par_err(perr),
    .o_cmd_err(cerr), .o_fault(fault), .o_all_well(well), .o_irq);
  cib_far_end cib_far_end_i (.i_clk, .i_ppr(pulse_point_reg), .i_sel(sel), .i_busy(busy), .i_mode(mode),
    .i_dly(dly), .i_rdata(rdata), .i_bus(dq), .o_data(far_dq), .o_ack(ack), .o_rdy(rdy),
    .o_perr(far_perr));
  task automatic chk(string nm, logic [35:0] e, logic [35:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // kind 0 plain, 1 bad ack, 2 silent far end, 3 spoilt read parity
  task automatic issue(int c, logic [5:0] s, logic [1:0] kd);
    int n;
    i_cmd_sel = 10'h1 << c;
    i_chan_sel = s;
    i_wr_data = $urandom;
    rdata = $urandom;
    dly = 4'($urandom % 6);
    mode = kd;
    qp.push_back({i_chan_sel, i_cmd_sel, ^i_wr_data[31:24], ^i_wr_data[23:16],
      ^i_wr_data[15:8], ^i_wr_data[7:0], i_wr_data});
    qd.push_back({i_cmd_sel, kd, rdata});
    i_cmd_go = 1'b1;
    @(negedge i_clk);
    i_cmd_go = 1'b0;
    for (n = 0; n < 100 && busy !== 1'b0; n++) @(negedge i_clk);
    if (n == 100) begin
      err_total++;
      final_report();
    end
  endtask : issue
  always @(negedge i_clk) begin
    logic [51:0] p;
    logic [43:0] d;
    if (cerr === 1'b1) n_cerr++;
    if (|pulse_point_reg && qp.size() > 0) begin
      p = qp.pop_front();
      chk("pulse", 36'(p[45:36]), 36'(pulse_point_reg));
      chk("sel", 36'(p[51:46]), 36'(sel));
      // every command but the four reads carries data out
      chk("oe", 36'(|p[45:40]), 36'(oe));
      if (|p[45:40]) chk("wdata", p[35:0], o_dq);
    end
    if (done === 1'b1 && qd.size() > 0) begin
      d = qd.pop_front();
      case (d[33:32])
        2'h0: begin
          if (|d[37:34]) chk("hold", 36'(d[31:0]), 36'(hold));
          else chk("far_perr", 36'h0, 36'(far_perr));
          chk("errs", 36'h0, 36'({aerr, rerr, perr}));
        end
        2'h1: chk("ack_err", 36'h1, 36'(aerr));
        2'h2: chk("rdy_err", 36'h1, 36'(rerr));
        default: chk("par_err", 36'h1, 36'(perr));
      endcase
    end
  end
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    {i_cmd_go, i_cmd_sel, i_chan_sel, i_wr_data, i_sys_state, i_irq_lines} = '0;
    {i_all_well_line, i_summary_fault_line, rdata, mode, dly} = '0;
    i_srst = 1'b1;
    void'($urandom(35613));
    repeat (12) @(negedge i_clk);
    i_srst = 1'b0;
    // pairs share a select so a lingering reply would be taken as fresh
    for (k = 0; k < 20; k++) issue(k % 10, k[1] ? 6'h2C : 6'h23, 2'h0);
    $display("test commands done");
    issue(0, 6'h25, 2'h1);
    issue(0, 6'h26, 2'h3);
    issue(1, 6'h31, 2'h2);
    $display("test reply faults done");
    i_chan_sel = 6'h0F;
    i_cmd_go = 1'b1;
    @(negedge i_clk);
    i_chan_sel = 6'h23;
    i_cmd_sel = 10'h3;
    @(negedge i_clk);
    i_cmd_go = 1'b0;
    repeat (3) @(negedge i_clk);
    chk("cmd_err", 36'h2, 36'(n_cerr));
    $display("test refusals done");
    for (k = 0; k < 8; k++) begin
      i_sys_state = $urandom;
      i_sys_state[9] = k[0];
      i_sys_state[30] = k[1];
      {i_irq_lines, i_all_well_line, i_summary_fault_line} = 8'($urandom);
      repeat (4) @(negedge i_clk);
      chk("block", 36'(k[0] | k[1]), 36'(blk));
      chk("sync", 36'({i_irq_lines, i_all_well_line, i_summary_fault_line}),
        36'({o_irq, well, fault}));
    end
    $display("test lines done");
    final_report();
  end
endmodule : cib_port_tb
